//--- hw/spc_fb_divider.v
// feedback divider of the multiplier: fixed prescaler by two, then by N
// assumes tick is a one-cycle event per rising oscillator edge, same clock domain
`timescale 1ns/1ps

module spc_fb_divider (
	input  wire       clk,
	input  wire       reset_n,
	input  wire       enable,
	input  wire       tick,
	input  wire [5:0] divisor,
	output reg        fb_fall
);

	reg       prescale;
	reg [5:0] count;
	wire      stage_step;

	// ********************************
	// prescaler and programmable stage
	// ********************************
	// second stage advances once per two ticks
	assign stage_step = tick & prescale;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale <= 1'b0;
			count    <= 6'h00;
			fb_fall  <= 1'b0;
		end else if (!enable) begin
			prescale <= 1'b0;
			count    <= 6'h00;
			fb_fall  <= 1'b0;
		end else begin
			if (tick) begin
				prescale <= ~prescale;
			end
			fb_fall <= 1'b0;
			if (stage_step) begin
				// wrap at divisor-1; a smaller new divisor at or below the count wraps on the next step
				if (count >= divisor - 6'h01) begin
					count   <= 6'h00;
					fb_fall <= 1'b1;
				end else begin
					count <= count + 6'h01;
				end
			end
		end
	end

endmodule // spc_fb_divider

//--- hw/spc_regs.vh
// register map, field positions and reset values of the system clock generator
// assumes a 32-bit AXI4-Lite register port with an 8-bit byte address
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

// ********************************
// addresses
// ********************************
`define SPC_ADDR_W        8
`define SPC_ADDR_CTRL     8'h10
`define SPC_ADDR_PLLCFG   8'h20
`define SPC_ADDR_UPDATE   8'h24
`define SPC_ADDR_STATUS   8'h30

// ********************************
// control register fields
// ********************************
`define SPC_CTRL_DBL_BIT   0
`define SPC_CTRL_ROUTE_BIT 1
`define SPC_CTRL_PD_BIT    4
`define SPC_CTRL_MASK      32'h00000013
`define SPC_CTRL_RST       32'h00000000

// ********************************
// multiplier setup fields
// ********************************
`define SPC_N_LSB          0
`define SPC_N_MSB          4
`define SPC_CP_LSB         8
`define SPC_CP_MSB         9
`define SPC_GAIN_BIT       12
`define SPC_N_RST          5'h12
`define SPC_CP_RST         2'h1
`define SPC_CP_MAX         2'h2
`define SPC_GAIN_RST       1'h1
`define SPC_N_BIAS         6'h02
`define SPC_UPDATE_BIT     0

// ********************************
// status fields
// ********************************
`define SPC_ST_SRC_BIT     0
`define SPC_ST_MULT_BIT    1
`define SPC_ST_UP_BIT      2
`define SPC_ST_DN_BIT      3
`define SPC_ST_N_LSB       8
`define SPC_ST_N_MSB       13
`define SPC_ST_RATIO_LSB   16
`define SPC_ST_RATIO_MSB   22

// ********************************
// bus answers
// ********************************
`define SPC_RESP_OKAY      2'h0
`define SPC_RESP_SLVERR    2'h2
`define SPC_ZERO32         32'h00000000

`endif

//--- hw/spc_top.v
// system clock generator control: source select, multiplier setup, return routing
// assumes an AXI4-Lite master on CLK; pin inputs are asynchronous to CLK
// How it works
// - multiplier path is enabled while the power-down bit reads zero; it resets to zero
// - source pin low keeps crystal amplifier on; high turns it off
// - source pin changes only the input, never the multiplier enable
// - multiplier off: buffered reference becomes the sampling clock; external 250 MHz-1 GHz
// - doubler on: a pulse on each rising and falling reference edge
// - phase detector acts only on falling edges of its input
// - charge pump picks one of three currents, 125 to 375 uA
// - register bit selects high or low oscillator gain
// - feedback divides by fixed two, then by N from 2 to 33
// - 5-bit field 0..31; hardware adds two to form N
// - reset ratio is 40, giving 1 GHz from 25 MHz
// - filtered return is squared and routed to primary driver or 2x multiplier
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "spc_regs.vh"

module spc_top (
	input  wire        CLK,
	input  wire        RESET_N,
	input  wire [7:0]  AWADDR,
	input  wire        AWVALID,
	output reg         AWREADY,
	input  wire [31:0] WDATA,
	input  wire [3:0]  WSTRB,
	input  wire        WVALID,
	output reg         WREADY,
	output reg  [1:0]  BRESP,
	output reg         BVALID,
	input  wire        BREADY,
	input  wire [7:0]  ARADDR,
	input  wire        ARVALID,
	output reg         ARREADY,
	output reg  [31:0] RDATA,
	output reg  [1:0]  RRESP,
	output reg         RVALID,
	input  wire        RREADY,
	input  wire        CLOCK_SOURCE_SELECT_PIN,
	input  wire        REFERENCE_CLOCK_INPUT,
	input  wire        OSC_FEEDBACK_INPUT,
	input  wire        FILTERED_RETURN_INPUT,
	output reg         XTAL_AMP_ENABLE,
	output reg         MULTIPLIER_ENABLE,
	output reg         SAMPLE_CLOCK,
	output reg         PFD_UP,
	output reg         PFD_DOWN,
	output reg  [1:0]  CHARGE_PUMP_SELECT,
	output reg         VCO_GAIN_HIGH,
	output reg  [5:0]  FEEDBACK_DIVISOR,
	output reg         PRIMARY_DRIVER_CLOCK,
	output reg         DOUBLER_INPUT_CLOCK
);

	// ********************************
	// address decode
	// ********************************
	function addr_mapped;
		input [7:0] addr;
		begin
			if (addr == `SPC_ADDR_CTRL)
				addr_mapped = 1'b1;
			else if (addr == `SPC_ADDR_PLLCFG)
				addr_mapped = 1'b1;
			else if (addr == `SPC_ADDR_UPDATE)
				addr_mapped = 1'b1;
			else if (addr == `SPC_ADDR_STATUS)
				addr_mapped = 1'b1;
			else
				addr_mapped = 1'b0;
		end
	endfunction

	function [31:0] merge_lanes;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer i;
		begin
			merge_lanes = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge_lanes[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
	endfunction

	// ********************************
	// pin synchronisers
	// ********************************
	// index 0 src, 1 ref, 2 osc, 3 return; stage a feeds stage b only
	wire [3:0] pin_raw;
	wire [3:0] sync_b;

	assign pin_raw = {FILTERED_RETURN_INPUT, OSC_FEEDBACK_INPUT,
	                  REFERENCE_CLOCK_INPUT, CLOCK_SOURCE_SELECT_PIN};

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sync
			// one flop pair per pin, so no vector has several driving processes
			reg stage_a;
			reg stage_b;
			always @(posedge CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					stage_a <= 1'b0;
					stage_b <= 1'b0;
				end else begin
					stage_a <= pin_raw[g];
					stage_b <= stage_a;
				end
			end
			assign sync_b[g] = stage_b;
		end
	endgenerate

	wire src_sel = sync_b[0];
	wire ref_lvl = sync_b[1];
	wire osc_lvl = sync_b[2];
	wire ret_lvl = sync_b[3]; // two-flop sampling squares the return

	// ********************************
	// registers
	// ********************************
	reg [31:0] ctrl_reg;
	reg [4:0]  staged_n;
	reg [1:0]  staged_cp;
	reg        staged_gain;
	reg [4:0]  active_n;
	reg [1:0]  active_cp;
	reg        active_gain;

	wire mult_en   = ~ctrl_reg[`SPC_CTRL_PD_BIT];
	wire dbl_en    = ctrl_reg[`SPC_CTRL_DBL_BIT];
	wire route_dbl = ctrl_reg[`SPC_CTRL_ROUTE_BIT];
	wire [5:0] eff_n = {1'b0, active_n} + `SPC_N_BIAS;
	wire [6:0] ratio = {eff_n, 1'b0};

	// ********************************
	// write channel
	// ********************************
	reg        aw_held;
	reg [7:0]  aw_addr;
	reg        w_held;
	reg [31:0] w_data;
	reg [3:0]  w_strb;

	wire aw_take  = AWVALID & AWREADY;
	wire w_take   = WVALID & WREADY;
	// commit one cycle after both halves are held and no answer is pending
	wire do_write = aw_held & w_held & ~BVALID;
	wire next_aw_held = (aw_held | aw_take) & ~do_write;
	wire next_w_held  = (w_held | w_take) & ~do_write;
	wire wr_ok    = addr_mapped(aw_addr);
	wire [31:0] cfg_now = {19'h00000, staged_gain, 2'h0, staged_cp, 3'h0, staged_n};
	wire [31:0] cfg_new = merge_lanes(cfg_now, w_data, w_strb);
	wire [31:0] ctrl_new = merge_lanes(ctrl_reg, w_data, w_strb) & `SPC_CTRL_MASK;
	wire [31:0] upd_new = merge_lanes(`SPC_ZERO32, w_data, w_strb);

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
			BVALID  <= 1'b0;
			BRESP   <= `SPC_RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			AWREADY <= ~next_aw_held;
			WREADY  <= ~next_w_held;
			if (aw_take)
				aw_addr <= AWADDR;
			if (w_take) begin
				w_data <= WDATA;
				w_strb <= WSTRB;
			end
			if (do_write) begin
				BVALID <= 1'b1;
				BRESP  <= wr_ok ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// register storage; only the update strobe moves staged values to the loop
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_reg    <= `SPC_CTRL_RST;
			staged_n    <= `SPC_N_RST;
			staged_cp   <= `SPC_CP_RST;
			staged_gain <= `SPC_GAIN_RST;
			active_n    <= `SPC_N_RST;
			active_cp   <= `SPC_CP_RST;
			active_gain <= `SPC_GAIN_RST;
		end else if (do_write) begin
			if (aw_addr == `SPC_ADDR_CTRL) begin
				ctrl_reg <= ctrl_new;
			end else if (aw_addr == `SPC_ADDR_PLLCFG) begin
				staged_n    <= cfg_new[`SPC_N_MSB:`SPC_N_LSB];
				staged_cp   <= cfg_new[`SPC_CP_MSB:`SPC_CP_LSB];
				staged_gain <= cfg_new[`SPC_GAIN_BIT];
			end else if (aw_addr == `SPC_ADDR_UPDATE) begin
				if (upd_new[`SPC_UPDATE_BIT]) begin
					active_n    <= staged_n;
					active_cp   <= staged_cp;
					active_gain <= staged_gain;
				end
			end
		end
	end

	// ********************************
	// read channel
	// ********************************
	reg [31:0] rd_mux;

	always @* begin
		rd_mux = `SPC_ZERO32;
		if (ARADDR == `SPC_ADDR_CTRL) begin
			rd_mux = ctrl_reg;
		end else if (ARADDR == `SPC_ADDR_PLLCFG) begin
			rd_mux = cfg_now;
		end else if (ARADDR == `SPC_ADDR_STATUS) begin
			rd_mux[`SPC_ST_SRC_BIT] = src_sel;
			rd_mux[`SPC_ST_MULT_BIT] = mult_en;
			rd_mux[`SPC_ST_UP_BIT] = PFD_UP;
			rd_mux[`SPC_ST_DN_BIT] = PFD_DOWN;
			rd_mux[`SPC_ST_N_MSB:`SPC_ST_N_LSB] = eff_n;
			rd_mux[`SPC_ST_RATIO_MSB:`SPC_ST_RATIO_LSB] = ratio;
		end
	end

	wire ar_take = ARVALID & ARREADY;

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h00000000;
			RRESP   <= `SPC_RESP_OKAY;
		end else begin
			if (ar_take) begin
				ARREADY <= 1'b0;
				RVALID  <= 1'b1;
				RDATA   <= rd_mux;
				RRESP   <= addr_mapped(ARADDR) ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
			end else if (RVALID && RREADY) begin
				RVALID  <= 1'b0;
				ARREADY <= 1'b1;
			end else if (!RVALID) begin
				ARREADY <= 1'b1;
			end
		end
	end

	// ********************************
	// reference edges and doubler
	// ********************************
	// edge model only: CLK cannot follow a GHz reference, this tracks slow stimulus
	reg ref_prev;
	reg osc_prev;
	reg dbl_pulse;
	reg dbl_prev;

	wire ref_rise = ref_lvl & ~ref_prev;
	wire ref_fall = ~ref_lvl & ref_prev;
	wire osc_tick = osc_lvl & ~osc_prev;

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ref_prev  <= 1'b0;
			osc_prev  <= 1'b0;
			dbl_pulse <= 1'b0;
			dbl_prev  <= 1'b0;
		end else begin
			ref_prev  <= ref_lvl;
			osc_prev  <= osc_lvl;
			dbl_pulse <= dbl_en & (ref_rise | ref_fall);
			dbl_prev  <= dbl_pulse;
		end
	end

	// detector sees the falling side of whichever train is selected
	wire pfd_ref_evt = mult_en & (dbl_en ? (dbl_prev & ~dbl_pulse) : ref_fall);

	// ********************************
	// feedback divider and detector
	// ********************************
	wire fb_evt;

	spc_fb_divider u_fb_div (
		.clk     (CLK),
		.reset_n (RESET_N),
		.enable  (mult_en),
		.tick    (osc_tick),
		.divisor (eff_n),
		.fb_fall (fb_evt)
	);

	wire up_set = PFD_UP | pfd_ref_evt;
	wire dn_set = PFD_DOWN | fb_evt;

	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PFD_UP   <= 1'b0;
			PFD_DOWN <= 1'b0;
		end else if (!mult_en || (up_set && dn_set)) begin
			PFD_UP   <= 1'b0;
			PFD_DOWN <= 1'b0;
		end else begin
			PFD_UP   <= up_set;
			PFD_DOWN <= dn_set;
		end
	end

	// ********************************
	// analog controls and clock routing
	// ********************************
	always @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			XTAL_AMP_ENABLE      <= 1'b1;
			MULTIPLIER_ENABLE    <= 1'b0;
			SAMPLE_CLOCK         <= 1'b0;
			CHARGE_PUMP_SELECT   <= `SPC_CP_RST;
			VCO_GAIN_HIGH        <= `SPC_GAIN_RST;
			FEEDBACK_DIVISOR     <= 6'h00;
			PRIMARY_DRIVER_CLOCK <= 1'b0;
			DOUBLER_INPUT_CLOCK  <= 1'b0;
		end else begin
			XTAL_AMP_ENABLE   <= ~src_sel;
			MULTIPLIER_ENABLE <= mult_en;
			// bypass hands the buffered reference straight on
			SAMPLE_CLOCK      <= mult_en ? osc_lvl : ref_lvl;
			// code 3 is not a level of its own; held at the top current
			CHARGE_PUMP_SELECT <= (active_cp > `SPC_CP_MAX) ? `SPC_CP_MAX : active_cp;
			VCO_GAIN_HIGH     <= active_gain;
			FEEDBACK_DIVISOR  <= eff_n;
			PRIMARY_DRIVER_CLOCK <= route_dbl ? 1'b0 : ret_lvl;
			DOUBLER_INPUT_CLOCK  <= route_dbl ? ret_lvl : 1'b0;
		end
	end

endmodule // spc_top

//--- testbench/spc_ref_src.sv
// reference source model: external oscillator on the reference pin
// assumes a 40 ns bench clock; every level is held for three or more clocks
`timescale 1ns/1ps
// ********************************
// source model
// ********************************
module spc_ref_src #(
	parameter int HALF_NS = 200,
	parameter int OSC_NS  = 120
) (
	output logic REF_OUT,
	output logic OSC_OUT
);
	// slow stand-in for the 250 MHz to 1 GHz source, free running like a real one
	initial begin
		REF_OUT = 1'b0;
		forever #HALF_NS REF_OUT = ~REF_OUT;
	end
	initial begin
		OSC_OUT = 1'b0;
		forever #OSC_NS OSC_OUT = ~OSC_OUT;
	end
endmodule // spc_ref_src

//--- testbench/spc_top_properties.sv
// concurrent checks on the clock generator top ports
// assumes one clock domain, bound into spc_top
`timescale 1ns/1ps
// ********************************
// checker
// ********************************
module spc_chk (
	input wire       CLK,
	input wire       RESET_N,
	input wire       BVALID,
	input wire       CLOCK_SOURCE_SELECT_PIN,
	input wire       REFERENCE_CLOCK_INPUT,
	input wire       OSC_FEEDBACK_INPUT,
	input wire       FILTERED_RETURN_INPUT,
	input wire       XTAL_AMP_ENABLE,
	input wire       MULTIPLIER_ENABLE,
	input wire       SAMPLE_CLOCK,
	input wire       PFD_UP,
	input wire       PFD_DOWN,
	input wire [1:0] CHARGE_PUMP_SELECT,
	input wire       VCO_GAIN_HIGH,
	input wire [5:0] FEEDBACK_DIVISOR,
	input wire       PRIMARY_DRIVER_CLOCK,
	input wire       DOUBLER_INPUT_CLOCK
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// edges since reset; sync pipes need three before pins show
	logic [2:0] rc;
	always @(posedge CLK or negedge RESET_N)
		if (!RESET_N) rc <= 3'h0;
		else if (rc != 3'h7) rc <= rc + 3'h1;
	sequence s_rel;
		rc == 3'h1;
	endsequence
	sequence s_cfg;
		rc > 3'h2 && ($changed(FEEDBACK_DIVISOR) || $changed(CHARGE_PUMP_SELECT)
			|| $changed(VCO_GAIN_HIGH));
	endsequence
	sequence s_off3;
		!MULTIPLIER_ENABLE && !$past(MULTIPLIER_ENABLE) && !$past(MULTIPLIER_ENABLE, 2);
	endsequence
	sequence s_on3;
		MULTIPLIER_ENABLE && $past(MULTIPLIER_ENABLE) && $past(MULTIPLIER_ENABLE, 2);
	endsequence
	// plain path: reference fell three samples back
	sequence s_fall;
		!$past(REFERENCE_CLOCK_INPUT, 3) && $past(REFERENCE_CLOCK_INPUT, 4);
	endsequence
	// doubler path: any reference edge, two samples later than the plain path
	sequence s_dbl;
		$past(REFERENCE_CLOCK_INPUT, 5) != $past(REFERENCE_CLOCK_INPUT, 6);
	endsequence
	AST_XTAL: assert property (rc > 3'h3 |->
		XTAL_AMP_ENABLE == !$past(CLOCK_SOURCE_SELECT_PIN, 3))
		else $error("xtal amp not inverse of select pin");
	AST_MULT_PIN: assert property (rc > 3'h1 && $changed(MULTIPLIER_ENABLE) |->
		BVALID || $past(BVALID))
		else $error("multiplier enable moved without a write");
	AST_BYPASS: assert property (rc > 3'h3 ##0 s_off3 |->
		SAMPLE_CLOCK == $past(REFERENCE_CLOCK_INPUT, 3))
		else $error("bypass sample clock not reference");
	AST_MULT_CLK: assert property (rc > 3'h3 ##0 s_on3 |->
		SAMPLE_CLOCK == $past(OSC_FEEDBACK_INPUT, 3))
		else $error("sample clock not oscillator");
	AST_ROUTE_P: assert property (rc > 3'h3 && PRIMARY_DRIVER_CLOCK |->
		$past(FILTERED_RETURN_INPUT, 3))
		else $error("primary clock without return");
	AST_ROUTE_X: assert property (!(PRIMARY_DRIVER_CLOCK && DOUBLER_INPUT_CLOCK))
		else $error("return routed to both paths");
	AST_DIV_RANGE: assert property (rc > 3'h0 |->
		FEEDBACK_DIVISOR inside {[6'h02:6'h21]})
		else $error("divisor out of range");
	AST_RESET_RATIO: assert property (s_rel |-> FEEDBACK_DIVISOR == 6'h14 && VCO_GAIN_HIGH)
		else $error("reset divisor not twenty");
	AST_PUMP: assert property (CHARGE_PUMP_SELECT != 2'h3)
		else $error("pump code three driven");
	AST_UPDATE: assert property (s_cfg |-> $past(BVALID))
		else $error("setting changed without update");
	AST_PFD_CLR: assert property (rc > 3'h3 && $rose(PFD_UP) |-> s_fall or s_dbl)
		else $error("detector up without a reference falling event");
	AST_PFD_OFF: assert property (!MULTIPLIER_ENABLE |-> !PFD_UP && !PFD_DOWN)
		else $error("detector active with multiplier off");
endmodule // spc_chk
bind spc_top spc_chk i_spc_chk (
	.CLK(CLK), .RESET_N(RESET_N), .BVALID(BVALID),
	.CLOCK_SOURCE_SELECT_PIN(CLOCK_SOURCE_SELECT_PIN),
	.REFERENCE_CLOCK_INPUT(REFERENCE_CLOCK_INPUT), .OSC_FEEDBACK_INPUT(OSC_FEEDBACK_INPUT),
	.FILTERED_RETURN_INPUT(FILTERED_RETURN_INPUT), .XTAL_AMP_ENABLE(XTAL_AMP_ENABLE),
	.MULTIPLIER_ENABLE(MULTIPLIER_ENABLE), .SAMPLE_CLOCK(SAMPLE_CLOCK),
	.PFD_UP(PFD_UP), .PFD_DOWN(PFD_DOWN), .CHARGE_PUMP_SELECT(CHARGE_PUMP_SELECT),
	.VCO_GAIN_HIGH(VCO_GAIN_HIGH), .FEEDBACK_DIVISOR(FEEDBACK_DIVISOR),
	.PRIMARY_DRIVER_CLOCK(PRIMARY_DRIVER_CLOCK), .DOUBLER_INPUT_CLOCK(DOUBLER_INPUT_CLOCK)
);

//--- testbench/test_reference_clock_input_pll_clock_generator.sv
// self-checking bench of the clock generator control block
// assumes spc_top on a 25 MHz clock; the source model drives the clock pins
`timescale 1ns/1ps
`include "spc_regs.vh"
// ********************************
// bench
// ********************************
module test_reference_clock_input_pll_clock_generator;
	logic        CLK, RESET_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID;
	logic        ARREADY, RVALID, RREADY, CLOCK_SOURCE_SELECT_PIN, REFERENCE_CLOCK_INPUT;
	logic        OSC_FEEDBACK_INPUT, FILTERED_RETURN_INPUT, XTAL_AMP_ENABLE, SAMPLE_CLOCK;
	logic        MULTIPLIER_ENABLE, PFD_UP, PFD_DOWN, VCO_GAIN_HIGH, PRIMARY_DRIVER_CLOCK;
	logic        DOUBLER_INPUT_CLOCK, g;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, d;
	logic [3:0]  WSTRB;
	logic [1:0]  BRESP, RRESP, CHARGE_PUMP_SELECT, r, cp;
	logic [5:0]  FEEDBACK_DIVISOR, fd_exp;
	logic [4:0]  n;
	int          err_count, total_checks, cyc;
	spc_top i_spc_top (
		.CLK(CLK), .RESET_N(RESET_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.CLOCK_SOURCE_SELECT_PIN(CLOCK_SOURCE_SELECT_PIN),
		.REFERENCE_CLOCK_INPUT(REFERENCE_CLOCK_INPUT),
		.OSC_FEEDBACK_INPUT(OSC_FEEDBACK_INPUT),
		.FILTERED_RETURN_INPUT(FILTERED_RETURN_INPUT),
		.XTAL_AMP_ENABLE(XTAL_AMP_ENABLE), .MULTIPLIER_ENABLE(MULTIPLIER_ENABLE),
		.SAMPLE_CLOCK(SAMPLE_CLOCK), .PFD_UP(PFD_UP), .PFD_DOWN(PFD_DOWN),
		.CHARGE_PUMP_SELECT(CHARGE_PUMP_SELECT), .VCO_GAIN_HIGH(VCO_GAIN_HIGH),
		.FEEDBACK_DIVISOR(FEEDBACK_DIVISOR), .PRIMARY_DRIVER_CLOCK(PRIMARY_DRIVER_CLOCK),
		.DOUBLER_INPUT_CLOCK(DOUBLER_INPUT_CLOCK)
	);
	spc_ref_src i_spc_ref_src (.REF_OUT(REFERENCE_CLOCK_INPUT), .OSC_OUT(OSC_FEEDBACK_INPUT));
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	// cut a hang short well past the expected few hundred cycles
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict;
		end
	end
	function logic [5:0] exp_div(input logic [4:0] f);
		return {1'b0, f} + `SPC_N_BIAS;
	endfunction
	function logic [1:0] exp_cp(input logic [1:0] c);
		return (c == 2'h3) ? `SPC_CP_MAX : c;
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		total_checks++;
		if (v !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, v);
		end
	endtask
	// each valid is held until its ready is seen, then dropped, so no write is taken twice
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		begin
			aw = 1'b0;
			w = 1'b0;
			AWADDR <= a;
			WDATA <= v;
			AWVALID <= 1'b1;
			WVALID <= 1'b1;
			while (!(aw && w)) begin
				@(posedge CLK);
				if (AWVALID && AWREADY === 1'b1) begin
					aw = 1'b1;
					AWVALID <= 1'b0;
				end
				if (WVALID && WREADY === 1'b1) begin
					w = 1'b1;
					WVALID <= 1'b0;
				end
			end
			do @(posedge CLK); while (BVALID !== 1'b1);
			r = BRESP;
		end
	endtask
	task rd(input logic [7:0] a);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge CLK); while (RVALID !== 1'b1);
		d = RDATA;
		r = RRESP;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h1b49));
		{RESET_N, AWVALID, WVALID, ARVALID, CLOCK_SOURCE_SELECT_PIN, FILTERED_RETURN_INPUT} <= 6'h00;
		{BREADY, RREADY, WSTRB, AWADDR, ARADDR, WDATA} <= {2'h3, 4'hF, 48'h0};
		fd_exp = 6'h14;
		repeat (10) @(posedge CLK);
		RESET_N <= 1'b1;
		repeat (4) @(posedge CLK);
		chk("mult_en", 1, MULTIPLIER_ENABLE);
		chk("xtal_on", 1, XTAL_AMP_ENABLE);
		chk("div_rst", fd_exp, FEEDBACK_DIVISOR);
		rd(`SPC_ADDR_CTRL);
		chk("ctrl_rst", 0, d);
		rd(`SPC_ADDR_PLLCFG);
		chk("setup_rst", 32'h00001112, d);
		rd(`SPC_ADDR_STATUS);
		chk("status_rst", 32'h00281402, d & 32'hFFFFFFF3);
		rd(8'h04);
		chk("unmap_resp", `SPC_RESP_SLVERR, r);
		chk("unmap_data", 0, d);
		wr(8'h04, 32'h00000010);
		chk("unmap_wr", `SPC_RESP_SLVERR, r);
		repeat (2) @(posedge CLK);
		chk("unmap_no_pd", 1, MULTIPLIER_ENABLE);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			n = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
			cp = (i == 2) ? 2'h3 : 2'($urandom % 3);
			g = 1'($urandom);
			wr(`SPC_ADDR_PLLCFG, {19'h0, g, 2'h0, cp, 3'h0, n});
			chk("cfg_resp", `SPC_RESP_OKAY, r);
			repeat (2) @(posedge CLK);
			chk("div_staged", fd_exp, FEEDBACK_DIVISOR);
			wr(`SPC_ADDR_UPDATE, 32'h1);
			repeat (2) @(posedge CLK);
			fd_exp = exp_div(n);
			chk("div", fd_exp, FEEDBACK_DIVISOR);
			chk("pump", exp_cp(cp), CHARGE_PUMP_SELECT);
			chk("gain", g, VCO_GAIN_HIGH);
			rd(`SPC_ADDR_STATUS);
			chk("ratio", {fd_exp, 1'b0}, d[22:16]);
		end
		$display("test setup done");
		CLOCK_SOURCE_SELECT_PIN <= 1'b1;
		repeat (5) @(posedge CLK);
		chk("xtal_off", 0, XTAL_AMP_ENABLE);
		chk("mult_kept", 1, MULTIPLIER_ENABLE);
		CLOCK_SOURCE_SELECT_PIN <= 1'b0;
		wr(`SPC_ADDR_CTRL, 32'h10);
		repeat (40) @(posedge CLK);
		chk("mult_off", 0, MULTIPLIER_ENABLE);
		rd(`SPC_ADDR_STATUS);
		chk("st_mult", 0, d[1]);
		FILTERED_RETURN_INPUT <= 1'b1;
		wr(`SPC_ADDR_CTRL, 32'h0);
		repeat (5) @(posedge CLK);
		chk("primary", 1, PRIMARY_DRIVER_CLOCK);
		wr(`SPC_ADDR_CTRL, 32'h3);
		repeat (5) @(posedge CLK);
		chk("to_2x", 1, DOUBLER_INPUT_CLOCK);
		chk("primary_off", 0, PRIMARY_DRIVER_CLOCK);
		// doubler on; detector and routing left to the checker
		for (int k = 0; k < 60; k++) begin
			FILTERED_RETURN_INPUT <= 1'($urandom);
			repeat (4) @(posedge CLK);
		end
		$display("test pins done");
		give_verdict;
	end
endmodule // test_reference_clock_input_pll_clock_generator
